/* pkg/dps_pkg.sv */
package dps_pkg;
    // clock: 200 MHz
    localparam int unsigned CLK_PERIOD_PS = 5000;

    // filter times in ns (18 us, 20 us, 20 us, 38 us, 3.5 us)
    localparam int unsigned UV_FILT_NS    = 18000;
    localparam int unsigned CB_FILT_NS    = 20000;
    localparam int unsigned PG_FILT_NS    = 20000;
    localparam int unsigned VCC_FILT_NS   = 38000;
    localparam int unsigned AUX_CLR_NS    = 3500;

    // least times round up to whole cycles, never below one
    function automatic int unsigned dps_cycles(input int unsigned t_ns);
        int unsigned c;
        c = (t_ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int unsigned UV_FILT_CYC  = dps_cycles(UV_FILT_NS);
    localparam int unsigned CB_FILT_CYC  = dps_cycles(CB_FILT_NS);
    localparam int unsigned PG_FILT_CYC  = dps_cycles(PG_FILT_NS);
    localparam int unsigned VCC_FILT_CYC = dps_cycles(VCC_FILT_NS);
    localparam int unsigned AUX_CLR_CYC  = dps_cycles(AUX_CLR_NS);

    // analog levels kept for reference only; neither the logic nor the bench uses them
    localparam int unsigned ACL_TO_CB_MAIN  = 2;   // main current limit = 2x breaker
    localparam int unsigned ACL_TO_CB_AUX   = 3;   // aux current limit ~3x breaker
    localparam int unsigned AUX_CB_MA       = 550; // aux breaker level, mA

    localparam int unsigned NSLOT = 2;
    localparam int unsigned SYNC_W = 1 + 15 * NSLOT;

    // switch group state
    typedef enum logic [1:0] {
        GS_OFF,
        GS_ON,
        GS_TRIPPED
    } dps_grp_st_t;
endpackage

/* rtl/dps_filter.sv */
`timescale 1ns/1ps
// qualifies a level: held rises once level has been high for CYCLES edges,
// and drops in the cycle after level falls
module dps_filter #(
    parameter int unsigned CYCLES  = 4,
    parameter bit          RST_VAL = 1'b0
) (
    input  wire logic clk_sys,  // system clock
    input  wire logic nrst,     // async reset, active low
    input  wire logic level,    // condition to qualify
    output logic      held      // condition held long enough
);
    localparam int unsigned W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_r;

    // counter restarts whenever the condition lapses
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
        end else if (!level) begin
            cnt_r <= '0;
        end else if (cnt_r != LAST) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // output flop; reset value chosen per use (lockout starts asserted)
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            held <= RST_VAL;
        end else begin
            held <= level && (held || cnt_r == LAST);
        end
    end
endmodule

/* rtl/dps_switch_ctrl.sv */
`timescale 1ns/1ps
module dps_switch_ctrl
    import dps_pkg::*;
#(
    parameter int unsigned VCC_FILT_CYCLES = VCC_FILT_CYC  // shorten in simulation
) (
    input  wire logic             clk_sys,            // 200 MHz system clock
    input  wire logic             nrst,               // async reset, active low
    input  wire logic             vcc_uv,             // device supply below lockout
    input  wire logic [NSLOT-1:0] in12_uv,            // 12 V input below lockout
    input  wire logic [NSLOT-1:0] in3_uv,             // 3.3 V input below lockout
    input  wire logic [NSLOT-1:0] aux_in_uv,          // aux input below lockout
    input  wire logic [NSLOT-1:0] present_n,          // slot presence, low = card in
    input  wire logic [NSLOT-1:0] main_on_cmd,        // main group on-command
    input  wire logic [NSLOT-1:0] aux_on_cmd,         // aux group on-command
    input  wire logic [NSLOT-1:0] force_on_diag,      // diagnostic force-on
    input  wire logic [NSLOT-1:0] cb12_oc,            // 12 V breaker_comparator trip level
    input  wire logic [NSLOT-1:0] cb3_oc,             // 3.3 V breaker_comparator
    input  wire logic [NSLOT-1:0] cbaux_oc,           // aux breaker_comparator
    input  wire logic [NSLOT-1:0] out12_pg_ok,        // 12 V output above good level
    input  wire logic [NSLOT-1:0] out3_pg_ok,         // 3.3 V output above good level
    input  wire logic [NSLOT-1:0] aux_out_pg_ok,      // aux output above good level
    input  wire logic [NSLOT-1:0] over_temp,          // aux switch over temperature
    input  wire logic [NSLOT-1:0] temp_recovered,     // aux switch cooled down
    output logic      [NSLOT-1:0] main_switch_en,     // main switch pair on
    output logic      [NSLOT-1:0] aux_switch_en,      // aux switch on
    output logic      [NSLOT-1:0] main_discharge_en,  // main output discharge on
    output logic      [NSLOT-1:0] aux_discharge_en,   // aux output discharge on
    output logic      [NSLOT-1:0] main_fault_n,       // main fault, active low
    output logic      [NSLOT-1:0] aux_fault_n,        // aux fault, active low
    output logic      [NSLOT-1:0] main_power_good_n,  // main power good, active low
    output logic      [NSLOT-1:0] aux_power_good_n    // aux power good, active low
);
    // all comparator and pin inputs come from outside the clock domain
    logic [SYNC_W-1:0] in_raw;
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync_r;

    logic             vcc_uv_s;
    logic [NSLOT-1:0] in12_uv_s, in3_uv_s, aux_uv_s, present_n_s;
    logic [NSLOT-1:0] main_cmd_s, aux_cmd_s, force_s;
    logic [NSLOT-1:0] cb12_s, cb3_s, cbaux_s;
    logic [NSLOT-1:0] pg12_s, pg3_s, pgaux_s, hot_s, cool_s;

    logic vcc_lock;  // filtered device lockout, shared by both slots

    assign in_raw = {vcc_uv, in12_uv, in3_uv, aux_in_uv, present_n, main_on_cmd,
                     aux_on_cmd, force_on_diag, cb12_oc, cb3_oc, cbaux_oc,
                     out12_pg_ok, out3_pg_ok, aux_out_pg_ok, over_temp, temp_recovered};

    // two-flop synchroniser on every input
    // the supply bit resets high so lockout cannot lapse before a real sample arrives
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_r <= {1'b1, {(SYNC_W-1){1'b0}}};
            sync_r  <= {1'b1, {(SYNC_W-1){1'b0}}};
        end else begin
            sync1_r <= in_raw;
            sync_r  <= sync1_r;
        end
    end

    assign {vcc_uv_s, in12_uv_s, in3_uv_s, aux_uv_s, present_n_s, main_cmd_s,
            aux_cmd_s, force_s, cb12_s, cb3_s, cbaux_s,
            pg12_s, pg3_s, pgaux_s, hot_s, cool_s} = sync_r;

    // lockout starts asserted so nothing switches before the first clean sample
    dps_filter #(
        .CYCLES  (VCC_FILT_CYCLES),
        .RST_VAL (1'b1)
    ) u_vcc_filt (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .level   (vcc_uv_s),
        .held    (vcc_lock)
    );

    for (genvar s = 0; s < NSLOT; s++) begin : g_slot
        // one independent controller per slot
        dps_grp_st_t main_st_r, aux_st_r;
        logic aux_heat_r;
        logic main_fault_r, aux_fault_r;
        logic main_pg_r, aux_pg_r;
        logic main_uv_f, aux_uv_f;
        logic trip12, trip3, tripaux;
        logic main_pg_bad, aux_pg_bad, aux_clr;
        logic main_in_ok, aux_in_ok, slot_in, force_act;
        logic main_trip, aux_trip, main_start, aux_start;
        logic main_stop, aux_stop, main_sw, aux_sw;

        // start needs device supply and group inputs out of lockout
        assign main_in_ok = !vcc_lock && !in12_uv_s[s] && !in3_uv_s[s];
        assign aux_in_ok  = !vcc_lock && !aux_uv_s[s];
        assign slot_in    = !present_n_s[s];
        assign force_act  = force_s[s] && slot_in;

        // either main input low long enough shuts both mains only
        dps_filter #(.CYCLES(UV_FILT_CYC), .RST_VAL(1'b0)) u_main_uv (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (in12_uv_s[s] || in3_uv_s[s]),
            .held    (main_uv_f)
        );
        dps_filter #(.CYCLES(UV_FILT_CYC), .RST_VAL(1'b0)) u_aux_uv (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (aux_uv_s[s]),
            .held    (aux_uv_f)
        );

        // breakers armed only while the group is on and its input is clear
        // a short at start-up sits at the analog limit until this expires
        dps_filter #(.CYCLES(CB_FILT_CYC), .RST_VAL(1'b0)) u_cb12 (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (cb12_s[s] && !in12_uv_s[s] && main_st_r == GS_ON),
            .held    (trip12)
        );
        dps_filter #(.CYCLES(CB_FILT_CYC), .RST_VAL(1'b0)) u_cb3 (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (cb3_s[s] && !in3_uv_s[s] && main_st_r == GS_ON),
            .held    (trip3)
        );
        // aux comparator level (550 mA, limit ~3x) is set in the analog front end
        dps_filter #(.CYCLES(CB_FILT_CYC), .RST_VAL(1'b0)) u_cbaux (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (cbaux_s[s] && !aux_uv_s[s] && aux_st_r == GS_ON),
            .held    (tripaux)
        );

        // output below good level for the filter time
        dps_filter #(.CYCLES(PG_FILT_CYC), .RST_VAL(1'b0)) u_main_pg (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (!(pg12_s[s] && pg3_s[s])),
            .held    (main_pg_bad)
        );
        dps_filter #(.CYCLES(PG_FILT_CYC), .RST_VAL(1'b0)) u_aux_pg (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (!pgaux_s[s]),
            .held    (aux_pg_bad)
        );

        // aux fault clear needs the command held low long enough
        dps_filter #(.CYCLES(AUX_CLR_CYC), .RST_VAL(1'b0)) u_aux_clr (
            .clk_sys (clk_sys),
            .nrst    (nrst),
            .level   (!aux_cmd_s[s]),
            .held    (aux_clr)
        );

        // force-on masks breaker trips; faults then show but do not latch
        assign main_trip = (trip12 || trip3) && !force_s[s];
        assign aux_trip  = tripaux && !force_s[s];

        // level check covers both "already high" and the later rising edge
        assign main_start = main_in_ok && slot_in && main_cmd_s[s] && !main_fault_r;
        assign aux_start  = aux_in_ok && slot_in && aux_cmd_s[s] && !aux_fault_r &&
                            !hot_s[s] && cool_s[s] && !aux_heat_r;

        // independent stop conditions per group
        assign main_stop = !main_cmd_s[s] || !slot_in || main_uv_f || vcc_lock;
        assign aux_stop  = !aux_cmd_s[s] || !slot_in || aux_uv_f || vcc_lock ||
                           hot_s[s];

        // main group sequencing
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                main_st_r <= GS_OFF;
            end else begin
                case (main_st_r)
                    GS_OFF: begin
                        if (main_start) begin
                            main_st_r <= GS_ON;
                        end
                    end
                    GS_ON: begin
                        if (main_trip) begin
                            main_st_r <= GS_TRIPPED;
                        end else if (main_stop) begin
                            main_st_r <= GS_OFF;
                        end
                    end
                    GS_TRIPPED: begin
                        if (!main_fault_r) begin
                            main_st_r <= GS_OFF;
                        end
                    end
                    default: main_st_r <= GS_OFF;
                endcase
            end
        end

        // aux group sequencing; overheat lands in tripped like a breaker trip
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                aux_st_r <= GS_OFF;
            end else begin
                case (aux_st_r)
                    GS_OFF: begin
                        if (aux_start) begin
                            aux_st_r <= GS_ON;
                        end
                    end
                    GS_ON: begin
                        if (aux_trip || hot_s[s]) begin
                            aux_st_r <= GS_TRIPPED;
                        end else if (aux_stop) begin
                            aux_st_r <= GS_OFF;
                        end
                    end
                    GS_TRIPPED: begin
                        if (!aux_fault_r) begin
                            aux_st_r <= GS_OFF;
                        end
                    end
                    default: aux_st_r <= GS_OFF;
                endcase
            end
        end

        // fault latches: set wins over clear; main frozen in force-on, aux still set by overheat in force-on
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                main_fault_r <= 1'b0;
            end else if (force_s[s]) begin
                main_fault_r <= main_fault_r;
            end else if (main_trip && main_st_r == GS_ON) begin
                main_fault_r <= 1'b1;
            end else if (!main_cmd_s[s] || in12_uv_s[s] || in3_uv_s[s] || vcc_lock) begin
                main_fault_r <= 1'b0;
            end
        end

        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                aux_fault_r <= 1'b0;
            end else if (aux_st_r == GS_ON && (hot_s[s] || (aux_trip && !force_s[s]))) begin
                aux_fault_r <= 1'b1;
            end else if (force_s[s]) begin
                aux_fault_r <= aux_fault_r;
            end else if (aux_clr || aux_uv_s[s] || vcc_lock) begin
                aux_fault_r <= 1'b0;
            end
        end

        // after overheat, restart waits for a low command seen once cooled, so a
        // recovery while the command stays high cannot restart aux by itself
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                aux_heat_r <= 1'b0;
            end else if (hot_s[s]) begin
                aux_heat_r <= 1'b1;
            end else if (!aux_cmd_s[s] && cool_s[s]) begin
                aux_heat_r <= 1'b0;
            end
        end

        // force-on overrides everything but lockout and an empty slot; heat still stops aux
        assign main_sw = !vcc_lock && (force_act || main_st_r == GS_ON);
        assign aux_sw  = !vcc_lock && !hot_s[s] && (force_act || aux_st_r == GS_ON);

        // good flags latch on first good sample, drop on filtered loss
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                main_pg_r <= 1'b0;
                aux_pg_r  <= 1'b0;
            end else begin
                main_pg_r <= main_sw && !main_pg_bad && (main_pg_r || (pg12_s[s] && pg3_s[s]));
                aux_pg_r  <= aux_sw && !aux_pg_bad && (aux_pg_r || pgaux_s[s]);
            end
        end

        // registered pin drive; discharge is the complement of the switch
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                main_switch_en[s]    <= 1'b0;
                aux_switch_en[s]     <= 1'b0;
                main_discharge_en[s] <= 1'b1;
                aux_discharge_en[s]  <= 1'b1;
            end else begin
                main_switch_en[s]    <= main_sw;
                aux_switch_en[s]     <= aux_sw;
                main_discharge_en[s] <= !main_sw;
                aux_discharge_en[s]  <= !aux_sw;
            end
        end

        // flags; under force-on a live overcurrent shows without latching
        always_ff @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
                main_fault_n[s]      <= 1'b1;
                aux_fault_n[s]       <= 1'b1;
                main_power_good_n[s] <= 1'b1;
                aux_power_good_n[s]  <= 1'b1;
            end else begin
                main_fault_n[s] <= !(main_fault_r ||
                                     (force_s[s] && (cb12_s[s] || cb3_s[s])));
                aux_fault_n[s]  <= !(aux_fault_r || (force_s[s] && cbaux_s[s]));
                // power-good needs every listed condition at once
                main_power_good_n[s] <= !(main_pg_r && slot_in && main_in_ok &&
                                          main_cmd_s[s]);
                aux_power_good_n[s]  <= !(aux_pg_r && slot_in && aux_in_ok &&
                                          aux_cmd_s[s] && !hot_s[s]);
            end
        end
    end
    // host-side insertion debounce is outside this block
endmodule

/* verif/dps_switch_ctrl_properties.sv */
`timescale 1ns/1ps
// mostly watches slot 0; the discharge and lockout checks cover both slots, the rest of slot 1 is judged by the bench
module dps_switch_ctrl_chk
    import dps_pkg::*;
#(
    parameter int unsigned VCC_FILT_CYCLES = 8  // device lockout filter
) (
    input wire logic             clk_sys,           // clock
    input wire logic             nrst,              // reset, active low
    input wire logic             vcc_uv,            // device supply low
    input wire logic [NSLOT-1:0] present_n,         // presence
    input wire logic [NSLOT-1:0] main_on_cmd,       // main command
    input wire logic [NSLOT-1:0] aux_on_cmd,        // aux command
    input wire logic [NSLOT-1:0] force_on_diag,     // force-on
    input wire logic [NSLOT-1:0] over_temp,         // overheat
    input wire logic [NSLOT-1:0] main_switch_en,    // main on
    input wire logic [NSLOT-1:0] aux_switch_en,     // aux on
    input wire logic [NSLOT-1:0] main_discharge_en, // main discharge
    input wire logic [NSLOT-1:0] aux_discharge_en,  // aux discharge
    input wire logic [NSLOT-1:0] main_fault_n,      // main fault
    input wire logic [NSLOT-1:0] main_power_good_n  // main good
);
    // margin covers sync flops, filter and output flop
    localparam int unsigned VLIM = VCC_FILT_CYCLES + 8;
    int unsigned vcnt_r;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // saturating count of lockout samples, so it never wraps
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) vcnt_r <= 0;
        else if (!vcc_uv) vcnt_r <= 0;
        else if (vcnt_r < VLIM) vcnt_r <= vcnt_r + 1;
    end
    chk_main_disch_inv: assert property (main_discharge_en == ~main_switch_en)
        else $error("main discharge not inverse of switch");
    chk_aux_disch_inv: assert property (aux_discharge_en == ~aux_switch_en)
        else $error("aux discharge not inverse of switch");
    chk_pg_release: assert property ($fell(main_switch_en[0]) |->
        ##[0:3] main_power_good_n[0])
        else $error("main power good held after switch off");
    chk_present_off: assert property (present_n[0] [*6] |->
        !main_switch_en[0] && !aux_switch_en[0])
        else $error("switch on with slot empty");
    chk_main_cmd_off: assert property ((!main_on_cmd[0] && !force_on_diag[0]) [*6] |->
        !main_switch_en[0])
        else $error("main on with command low");
    chk_aux_cmd_off: assert property ((!aux_on_cmd[0] && !force_on_diag[0]) [*6] |->
        !aux_switch_en[0])
        else $error("aux on with command low");
    chk_overheat_aux: assert property (over_temp[0] [*4] |-> !aux_switch_en[0])
        else $error("aux on while overheated");
    chk_trip_off: assert property ($fell(main_fault_n[0]) && !force_on_diag[0] |->
        ##[0:2] !main_switch_en[0])
        else $error("main on after trip");
    chk_vcc_all_off: assert property (vcnt_r == VLIM |->
        main_switch_en == '0 && aux_switch_en == '0)
        else $error("switch on in device lockout");
endmodule
bind dps_switch_ctrl dps_switch_ctrl_chk #(.VCC_FILT_CYCLES(VCC_FILT_CYCLES)) u_chk (
    .clk_sys, .nrst, .vcc_uv, .present_n, .main_on_cmd, .aux_on_cmd, .force_on_diag,
    .over_temp, .main_switch_en, .aux_switch_en, .main_discharge_en, .aux_discharge_en,
    .main_fault_n, .main_power_good_n);

/* verif/dps_host_model.sv */
`timescale 1ns/1ps
// host side: a slot's commands stay low until its insertion debounce runs out
module dps_host_model
    import dps_pkg::*;
#(
    parameter int unsigned DEB_CYCLES = 16  // debounce, shortened
) (
    input  wire logic             clk_sys,     // clock
    input  wire logic             nrst,        // reset, active low
    input  wire logic [NSLOT-1:0] present_n,   // presence, low = card in
    input  wire logic [NSLOT-1:0] want_main,   // bench asks for main
    input  wire logic [NSLOT-1:0] want_aux,    // bench asks for aux
    output logic      [NSLOT-1:0] main_on_cmd, // main command
    output logic      [NSLOT-1:0] aux_on_cmd   // aux command
);
    int unsigned      deb_r [NSLOT];
    logic [NSLOT-1:0] ready;
    // falling edge keeps changes off the sampling edge; removal restarts the count
    always_ff @(negedge clk_sys) begin
        for (int i = 0; i < NSLOT; i++) begin
            if (!nrst || present_n[i]) deb_r[i] <= 0;
            else if (deb_r[i] < DEB_CYCLES) deb_r[i] <= deb_r[i] + 1;
        end
    end
    always_comb begin
        for (int i = 0; i < NSLOT; i++) ready[i] = (deb_r[i] == DEB_CYCLES);
    end
    // a low request is held low as long as asked, which clears faults
    assign main_on_cmd = want_main & ready;
    assign aux_on_cmd  = want_aux & ready;
endmodule

/* verif/test_dual_slot_power_switch_control.sv */
`timescale 1ns/1ps
module test_dual_slot_power_switch_control
    import dps_pkg::*;
;
    logic             clk_sys, nrst, vcc_uv;
    logic [NSLOT-1:0] in12_uv, in3_uv, aux_in_uv, present_n, want_main, want_aux;
    logic [NSLOT-1:0] force_on_diag, cb12_oc, cb3_oc, cbaux_oc, out12_pg_ok, out3_pg_ok;
    logic [NSLOT-1:0] aux_out_pg_ok, over_temp, temp_recovered, main_on_cmd, aux_on_cmd;
    logic [NSLOT-1:0] main_switch_en, aux_switch_en, main_discharge_en, aux_discharge_en;
    logic [NSLOT-1:0] main_fault_n, aux_fault_n, main_power_good_n, aux_power_good_n;
    int               errors, samples_checked;
    dps_switch_ctrl #(.VCC_FILT_CYCLES(8)) DUT (.clk_sys, .nrst, .vcc_uv, .in12_uv,
        .in3_uv, .aux_in_uv, .present_n, .main_on_cmd, .aux_on_cmd, .force_on_diag,
        .cb12_oc, .cb3_oc, .cbaux_oc, .out12_pg_ok, .out3_pg_ok, .aux_out_pg_ok,
        .over_temp, .temp_recovered, .main_switch_en, .aux_switch_en, .main_discharge_en,
        .aux_discharge_en, .main_fault_n, .aux_fault_n, .main_power_good_n,
        .aux_power_good_n);
    dps_host_model HOST (.clk_sys, .nrst, .present_n, .want_main, .want_aux,
        .main_on_cmd, .aux_on_cmd);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // inputs change only at falling edges, away from sampling
    task automatic wc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic chk(input logic [NSLOT-1:0] g, input logic [NSLOT-1:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic s_start;
        chk(main_switch_en | aux_switch_en, 2'b00);
        chk(main_fault_n & aux_fault_n & main_power_good_n, 2'b11);
        want_main = 2'b11;
        want_aux = 2'b01;
        present_n = 2'b10;
        wc(40);
        chk(main_switch_en, 2'b01);
        chk(aux_switch_en, 2'b01);
        chk(main_power_good_n & aux_power_good_n, 2'b10);
        chk(main_discharge_en, 2'b10);
        want_main = 2'b10;
        wc(10);
        chk(main_switch_en, 2'b00);
        chk(aux_switch_en, 2'b01);
        chk(main_power_good_n, 2'b11);
        want_main = 2'b11;
        wc(10);
        chk(main_switch_en, 2'b01);
    endtask
    task automatic s_trip;
        cb12_oc[0] = 1'b1;
        wc(CB_FILT_CYC / 2);
        cb12_oc[0] = 1'b0;
        wc(10);
        chk(main_fault_n & main_switch_en, 2'b01);
        cb3_oc[0] = 1'b1;
        wc(CB_FILT_CYC + 20);
        cb3_oc[0] = 1'b0;
        chk(main_switch_en, 2'b00);
        chk(aux_switch_en, 2'b01);
        wc(10);
        chk(main_fault_n, 2'b10);
        want_main = 2'b10;
        wc(10);
        chk(main_fault_n, 2'b11);
        want_main = 2'b11;
        cbaux_oc[0] = 1'b1;
        wc(CB_FILT_CYC + 20);
        cbaux_oc[0] = 1'b0;
        chk(aux_switch_en, 2'b00);
        chk(main_switch_en, 2'b01);
        want_aux = 2'b00;
        wc(AUX_CLR_CYC / 2);
        chk(aux_fault_n, 2'b10);
        wc(AUX_CLR_CYC);
        chk(aux_fault_n, 2'b11);
        want_aux = 2'b01;
        wc(10);
        chk(aux_switch_en, 2'b01);
    endtask
    task automatic s_heat;
        temp_recovered[0] = 1'b0;
        over_temp[0] = 1'b1;
        wc(8);
        over_temp[0] = 1'b0;
        chk(aux_switch_en | ~main_switch_en, 2'b10);
        chk(aux_fault_n, 2'b10);
        want_aux = 2'b00;
        wc(AUX_CLR_CYC + 20);
        want_aux = 2'b01;
        wc(10);
        chk(aux_switch_en, 2'b00);
        temp_recovered[0] = 1'b1;
        wc(10);
        chk(aux_switch_en, 2'b00);
        want_aux = 2'b00;
        wc(AUX_CLR_CYC + 20);
        want_aux = 2'b01;
        wc(10);
        chk(aux_switch_en, 2'b01);
    endtask
    task automatic s_uv;
        in3_uv[0] = 1'b1;
        wc(UV_FILT_CYC / 2);
        in3_uv[0] = 1'b0;
        wc(10);
        chk(main_switch_en, 2'b01);
        in3_uv[0] = 1'b1;
        wc(UV_FILT_CYC + 20);
        chk(main_switch_en | ~aux_switch_en, 2'b10);
        in3_uv[0] = 1'b0;
        aux_in_uv[0] = 1'b1;
        wc(UV_FILT_CYC + 20);
        chk(aux_switch_en | ~main_switch_en, 2'b10);
        aux_in_uv[0] = 1'b0;
        wc(10);
        chk(main_switch_en & aux_switch_en, 2'b01);
    endtask
    task automatic s_misc;
        out12_pg_ok[0] = 1'b0;
        wc(PG_FILT_CYC / 2);
        chk(main_power_good_n, 2'b10);
        wc(PG_FILT_CYC);
        chk(main_power_good_n, 2'b11);
        out12_pg_ok[0] = 1'b1;
        vcc_uv = 1'b1;
        wc(30);
        chk(main_switch_en | aux_switch_en, 2'b00);
        vcc_uv = 1'b0;
        want_main = 2'b10;
        force_on_diag[0] = 1'b1;
        wc(20);
        chk(main_switch_en, 2'b01);
        vcc_uv = 1'b1;
        wc(30);
        chk(main_switch_en | aux_switch_en, 2'b00);
        vcc_uv = 1'b0;
        force_on_diag[0] = 1'b0;
        want_main = 2'b11;
        wc(20);
        chk(main_switch_en & aux_switch_en, 2'b01);
        present_n = 2'b11;
        wc(10);
        chk(main_switch_en | aux_switch_en, 2'b00);
        chk(main_power_good_n & aux_power_good_n, 2'b11);
    endtask
    initial begin
        nrst = 1'b0;
        vcc_uv = 1'b0;
        {in12_uv, in3_uv, aux_in_uv, force_on_diag, cb12_oc, cb3_oc, cbaux_oc} = '0;
        {over_temp, want_main, want_aux} = '0;
        {present_n, out12_pg_ok, out3_pg_ok, aux_out_pg_ok, temp_recovered} = '1;
        errors = 0;
        samples_checked = 0;
        wc(10);
        nrst = 1'b1;
        wc(5);
        s_start;
        s_trip;
        s_heat;
        s_uv;
        s_misc;
        conclude;
    end
    // the whole sequence takes about 28000 cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        errors++;
        conclude;
    end
endmodule
